// file: hdl/ssa_core.sv
// Stack pointer, frame pointer and status handling of a 16-bit core, with its
// operand address front end. Assumes one clock and a data memory that takes a
// write or read in the cycle its strobe is high and returns read data next cycle.
//
// Behaviour
// - Stack pointer auto-updated on exceptions, calls, returns; still read/written as register.
// - Stack pointer bit zero always reads zero.
// - Stack pointer resets to 0x1000.
// - Software may move the stack pointer to any even address; later stack use follows it.
// - Pointer addresses first free word; push writes then increments, pop decrements then reads.
// - Program counter low word pushed first, then bits 22 to 16.
// - Call pushes upper program counter bits zero-extended.
// - Exception merges status low byte into the upper pushed word.
// - Stack accesses never paged; 16-bit address range only.
// - Frame pointer, when enabled, likewise unpaged and 16-bit only.
// - File-register instructions use 13-bit direct addresses in near data space.
// - File-register ops imply working register zero; destination file or it, multiply aside.
// - Move instruction reaches all of data space.
// - Three-operand: first source register direct; second register, memory or 5-bit literal.
// - Modes: direct, indirect, post-modify, pre-modify, 5- or 10-bit literal.
module ssa_core
    import ssa_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Stack requests from the sequencer
    input wire logic call_req,
    input wire logic exc_req,
    input wire logic ret_req,
    input wire logic retfie_req,
    input wire logic [22:0] pc_in,
    output logic stk_busy,
    output logic stk_done,
    output logic [22:0] pc_out,
    output logic pc_out_valid,
    // Paging request for frame pointer accesses
    input wire logic fp_access,
    output logic fp_unpaged,
    // Operand request from decode
    input wire logic [1:0] op_class,
    input wire logic [2:0] op_mode,
    input wire logic [12:0] op_file_addr,
    input wire logic [15:0] op_full_addr,
    input wire logic [9:0] op_literal,
    input wire logic op_dest_file,
    input wire logic op_valid,
    output logic [15:0] op_ea,
    output logic op_is_lit,
    output logic op_illegal,
    output logic op_dest_implied_work_alias,
    output logic op_wb_direct,
    // Data memory
    output logic mem_wr,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic mem_paged,
    input wire logic [15:0] mem_rdata
);
    `include "ssa_map.svh"

    logic [15:0] stack_pointer_reg;
    logic [15:0] frame_pointer_reg;
    logic [15:0] default_work_reg;
    logic [15:0] cpu_status_reg;
    logic [15:0] core_control_reg;
    ssa_state_e state;
    logic is_exc;
    logic is_retfie;
    logic is_pop;
    logic [22:0] pc_hold;
    logic [15:0] pop_hi;
    logic [15:0] sp_step;
    logic sp_auto;
    logic frame_pointer_active;

    ssa_agen_if ag_bus ();

    ssa_agen u_agen
    (
        .ag(ag_bus)
    );

    assign frame_pointer_active = core_control_reg[`SSA_CORCTL_SFA_BIT];
    assign ag_bus.op_class = op_class;
    assign ag_bus.mode = op_mode;
    assign ag_bus.file_addr = op_file_addr;
    assign ag_bus.full_addr = op_full_addr;
    assign ag_bus.literal = op_literal;
    // File-register forms work against the implied register; three-operand forms use it as base.
    assign ag_bus.implied_work_alias_val = default_work_reg;

    // Stack state machine: one word moves per cycle.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= SSA_ST_IDLE;
            is_exc <= 1'b0;
            is_retfie <= 1'b0;
            is_pop <= 1'b0;
            pc_hold <= 23'h000000;
            pop_hi <= 16'h0000;
        end
        else
        begin
            case (state)
                SSA_ST_IDLE:
                begin
                    if (call_req || exc_req)
                    begin
                        state <= SSA_ST_PUSH_LO;
                        is_exc <= exc_req;
                        is_retfie <= 1'b0;
                        is_pop <= 1'b0;
                        pc_hold <= pc_in;
                    end
                    else if (ret_req || retfie_req)
                    begin
                        state <= SSA_ST_POP_HI;
                        is_retfie <= retfie_req;
                        is_pop <= 1'b1;
                    end
                end
                SSA_ST_PUSH_LO: state <= SSA_ST_PUSH_HI;
                SSA_ST_PUSH_HI: state <= SSA_ST_DONE;
                SSA_ST_POP_HI: state <= SSA_ST_POP_LO;
                SSA_ST_POP_LO:
                begin
                    pop_hi <= mem_rdata;
                    state <= SSA_ST_DONE;
                end
                SSA_ST_DONE: state <= SSA_ST_IDLE;
                default: state <= SSA_ST_IDLE;
            endcase
        end
    end

    // Memory strobes and stack words, taken from the pointer without paging.
    always_comb
    begin
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_addr = 16'h0000;
        mem_wdata = 16'h0000;
        sp_step = stack_pointer_reg;
        sp_auto = 1'b0;
        case (state)
            SSA_ST_PUSH_LO:
            begin
                mem_wr = 1'b1;
                mem_addr = stack_pointer_reg;
                mem_wdata = pc_hold[15:0];
                sp_step = stack_pointer_reg + 16'h0002;
                sp_auto = 1'b1;
            end
            SSA_ST_PUSH_HI:
            begin
                mem_wr = 1'b1;
                mem_addr = stack_pointer_reg;
                if (is_exc)
                begin
                    mem_wdata = {cpu_status_reg[7:0], 1'b0, pc_hold[22:16]};
                end
                else
                begin
                    mem_wdata = {9'h000, pc_hold[22:16]};
                end
                sp_step = stack_pointer_reg + 16'h0002;
                sp_auto = 1'b1;
            end
            SSA_ST_POP_HI:
            begin
                mem_rd = 1'b1;
                mem_addr = stack_pointer_reg - 16'h0002;
                sp_step = stack_pointer_reg - 16'h0002;
                sp_auto = 1'b1;
            end
            SSA_ST_POP_LO:
            begin
                mem_rd = 1'b1;
                mem_addr = stack_pointer_reg - 16'h0002;
                sp_step = stack_pointer_reg - 16'h0002;
                sp_auto = 1'b1;
            end
            default:
            begin
                mem_wr = 1'b0;
            end
        endcase
    end

    // Stack accesses are never paged; frame pointer accesses are unpaged only when enabled in the core control register.
    assign mem_paged = 1'b0;
    assign fp_unpaged = fp_access && frame_pointer_active;
    assign stk_busy = (state != SSA_ST_IDLE);

    // Stack pointer: automatic steps have priority over a software write.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stack_pointer_reg <= `SSA_RST_SP;
        end
        else if (sp_auto)
        begin
            stack_pointer_reg <= {sp_step[15:1], 1'b0};
        end
        else if (reg_wr && (reg_addr == `SSA_OFF_SP))
        begin
            stack_pointer_reg <= {reg_wdata[15:1], 1'b0};
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            frame_pointer_reg <= 16'h0000;
        end
        else if (reg_wr && (reg_addr == `SSA_OFF_FP))
        begin
            frame_pointer_reg <= reg_wdata;
        end
    end

    // Implied working register also takes post/pre modify write-back.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            default_work_reg <= 16'h0000;
        end
        else if (reg_wr && (reg_addr == `SSA_OFF_W0))
        begin
            default_work_reg <= reg_wdata;
        end
        else if (op_valid && ag_bus.implied_work_alias_upd && !ag_bus.illegal)
        begin
            default_work_reg <= ag_bus.implied_work_alias_next;
        end
    end

    // Exception return restores the saved status byte.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cpu_status_reg <= `SSA_RST_STATUS;
        end
        else if (state == SSA_ST_DONE && is_pop && is_retfie)
        begin
            cpu_status_reg <= {cpu_status_reg[15:8], pop_hi[15:8]};
        end
        else if (reg_wr && (reg_addr == `SSA_OFF_STATUS))
        begin
            cpu_status_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_control_reg <= `SSA_RST_CORCTL;
        end
        else if (reg_wr && (reg_addr == `SSA_OFF_CORCTL))
        begin
            core_control_reg <= reg_wdata;
        end
    end

    // The lower popped word only arrives in the done state, so a pop answers one
    // cycle later than a push does.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stk_done <= 1'b0;
            pc_out <= 23'h000000;
            pc_out_valid <= 1'b0;
        end
        else
        begin
            stk_done <= (state == SSA_ST_PUSH_HI) || ((state == SSA_ST_DONE) && is_pop);
            pc_out_valid <= (state == SSA_ST_DONE) && is_pop;
            if ((state == SSA_ST_DONE) && is_pop)
            begin
                pc_out <= {pop_hi[6:0], mem_rdata};
            end
        end
    end

    // Operand answers are registered one cycle after the request.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            op_ea <= 16'h0000;
            op_is_lit <= 1'b0;
            op_illegal <= 1'b0;
            op_dest_implied_work_alias <= 1'b0;
            op_wb_direct <= 1'b0;
        end
        else if (op_valid)
        begin
            op_ea <= ag_bus.ea;
            op_is_lit <= ag_bus.is_lit;
            op_illegal <= ag_bus.illegal;
            op_dest_implied_work_alias <= (op_class == SSA_INS_FILE) && !op_dest_file;
            op_wb_direct <= (op_class == SSA_INS_THREE);
        end
    end

    // Register read port: data one cycle after the read strobe.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `SSA_OFF_SP: reg_rdata <= stack_pointer_reg;
                `SSA_OFF_FP: reg_rdata <= frame_pointer_reg;
                `SSA_OFF_W0: reg_rdata <= default_work_reg;
                `SSA_OFF_STATUS: reg_rdata <= cpu_status_reg;
                `SSA_OFF_CORCTL: reg_rdata <= core_control_reg;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// file: hdl/ssa_map.svh
// Register offsets, field positions, reset values and address limits of the stack block.
// Included by the package user modules; definitions only.
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH
`define SSA_OFF_STATUS 16'h0042
`define SSA_OFF_CORCTL 16'h0044
`define SSA_OFF_SP 16'h001e
`define SSA_OFF_FP 16'h001c
`define SSA_OFF_W0 16'h0000
`define SSA_RST_STATUS 16'h0000
`define SSA_RST_CORCTL 16'h0020
`define SSA_RST_SP 16'h1000
`define SSA_CORCTL_SFA_BIT 2
`define SSA_NEAR_LIMIT 16'h2000
`define SSA_LIT5_W 5
`define SSA_LIT10_W 10
`endif

// file: hdl/ssa_pkg.sv
// Types shared by the stack and addressing block.
// Assumes ssa_map.svh holds every numeric constant.
package ssa_pkg;
    typedef enum logic [2:0]
    {
        SSA_AM_DIRECT = 3'h0,
        SSA_AM_INDIRECT = 3'h1,
        SSA_AM_POST = 3'h2,
        SSA_AM_PRE = 3'h3,
        SSA_AM_LIT5 = 3'h4,
        SSA_AM_LIT10 = 3'h5
    } ssa_mode_e;
    typedef enum logic [1:0]
    {
        SSA_INS_FILE = 2'h0,
        SSA_INS_MOVE = 2'h1,
        SSA_INS_MUL = 2'h2,
        SSA_INS_THREE = 2'h3
    } ssa_class_e;
    typedef enum logic [5:0]
    {
        SSA_ST_IDLE = 6'h01,
        SSA_ST_PUSH_LO = 6'h02,
        SSA_ST_PUSH_HI = 6'h04,
        SSA_ST_POP_HI = 6'h08,
        SSA_ST_POP_LO = 6'h10,
        SSA_ST_DONE = 6'h20
    } ssa_state_e;
endpackage

// file: hdl/ssa_agen_if.sv
// Carrier between the stack core and its operand address generator.
// Assumes both ends run on the same clock.
interface ssa_agen_if;
    import ssa_pkg::*;
    logic [1:0] op_class;
    logic [2:0] mode;
    logic [12:0] file_addr;
    logic [15:0] implied_work_alias_val;
    logic [15:0] full_addr;
    logic [9:0] literal;
    logic [15:0] ea;
    logic [15:0] implied_work_alias_next;
    logic implied_work_alias_upd;
    logic is_lit;
    logic illegal;
    modport core (output op_class, mode, file_addr, implied_work_alias_val, full_addr, literal,
        input ea, implied_work_alias_next, implied_work_alias_upd, is_lit, illegal);
    modport agen (input op_class, mode, file_addr, implied_work_alias_val, full_addr, literal,
        output ea, implied_work_alias_next, implied_work_alias_upd, is_lit, illegal);
endinterface

// file: hdl/ssa_agen.sv
// Operand address generator: file-register, move and three-operand modes.
// Assumes a word-sized post/pre modify step of two bytes.
module ssa_agen
    import ssa_pkg::*;
(
    // Request and answer
    ssa_agen_if.agen ag
);
    `include "ssa_map.svh"
    localparam logic [15:0] STEP = 16'h0002;
    ssa_mode_e m;
    ssa_class_e c;
    always_comb
    begin
        m = ssa_mode_e'(ag.mode);
        c = ssa_class_e'(ag.op_class);
        ag.ea = 16'h0000;
        ag.implied_work_alias_next = ag.implied_work_alias_val;
        ag.implied_work_alias_upd = 1'b0;
        ag.is_lit = 1'b0;
        ag.illegal = 1'b0;
        case (c)
            SSA_INS_FILE, SSA_INS_MUL:
                ag.ea = {3'h0, ag.file_addr};
            SSA_INS_MOVE:
                ag.ea = ag.full_addr;
            SSA_INS_THREE:
            begin
                case (m)
                    SSA_AM_DIRECT: ag.ea = ag.implied_work_alias_val;
                    SSA_AM_INDIRECT: ag.ea = ag.implied_work_alias_val;
                    SSA_AM_POST:
                    begin
                        ag.ea = ag.implied_work_alias_val;
                        ag.implied_work_alias_next = ag.implied_work_alias_val + STEP;
                        ag.implied_work_alias_upd = 1'b1;
                    end
                    SSA_AM_PRE:
                    begin
                        ag.ea = ag.implied_work_alias_val - STEP;
                        ag.implied_work_alias_next = ag.implied_work_alias_val - STEP;
                        ag.implied_work_alias_upd = 1'b1;
                    end
                    SSA_AM_LIT5:
                    begin
                        ag.ea = {11'h000, ag.literal[`SSA_LIT5_W-1:0]};
                        ag.is_lit = 1'b1;
                    end
                    SSA_AM_LIT10:
                    begin
                        ag.ea = {6'h00, ag.literal};
                        ag.is_lit = 1'b1;
                    end
                    default: ag.illegal = 1'b1;
                endcase
            end
            default: ag.illegal = 1'b1;
        endcase
        // Only three-operand forms accept every mode; others are flagged outside direct mode.
        if ((c != SSA_INS_THREE) && (m != SSA_AM_DIRECT))
        begin
            ag.illegal = 1'b1;
        end
    end
endmodule

// file: tb/ssa_mem_model.sv
// Data memory model that answers the stack block's memory strobes.
// Assumes one clock; read data stand in the cycle after the read strobe only.
module ssa_mem_model
(
    // Clock
    input wire logic clk_sys,
    // Memory port
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] store [0:32767];
    initial mem_rdata = 16'h0000;
    // Outside a read answer the data lines show the inverse, so stale data never pass.
    always @(posedge clk_sys)
    begin
        if (mem_wr)
            store[mem_addr[15:1]] <= mem_wdata;
        if (mem_rd)
            mem_rdata <= store[mem_addr[15:1]];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// file: tb/ssa_core_chk.sv
// Concurrent checks on the ports of the stack and addressing core.
// Assumes it is bound to ssa_core and watches its port signals only.
`include "ssa_map.svh"
module ssa_core_chk
    import ssa_pkg::*;
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic call_req,
    input wire logic exc_req,
    input wire logic ret_req,
    input wire logic retfie_req,
    input wire logic [22:0] pc_in,
    input wire logic stk_busy,
    input wire logic stk_done,
    input wire logic pc_out_valid,
    input wire logic fp_access,
    input wire logic fp_unpaged,
    input wire logic [1:0] op_class,
    input wire logic [2:0] op_mode,
    input wire logic [15:0] op_full_addr,
    input wire logic op_valid,
    input wire logic [15:0] op_ea,
    input wire logic op_illegal,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_paged
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic push_go;
    logic pop_go;
    assign push_go = (call_req | exc_req) & ~stk_busy;
    assign pop_go = (ret_req | retfie_req) & ~call_req & ~exc_req & ~stk_busy;
    sequence push_pair;
        mem_wr ##1 (mem_wr && mem_addr == $past(mem_addr) + 16'h0002);
    endsequence
    sequence pop_pair;
        mem_rd ##1 (mem_rd && mem_addr == $past(mem_addr) - 16'h0002);
    endsequence
    chk_sp_even_read: assert property (reg_rd && reg_addr == `SSA_OFF_SP |=> !reg_rdata[0])
        else $error("stack pointer read back odd");
    chk_push_low_first: assert property (push_go |=> mem_wdata == $past(pc_in[15:0]))
        else $error("first pushed word is not the low program counter");
    chk_push_upward: assert property (push_go |=> push_pair)
        else $error("push words not at rising addresses");
    chk_call_zero_ext: assert property (push_go && !exc_req |=> ##1 mem_wdata == {9'h000, $past(pc_in[22:16], 2)})
        else $error("call upper word not zero extended");
    chk_pop_downward: assert property (pop_go |=> pop_pair)
        else $error("pop reads not at falling addresses");
    chk_stack_done_time: assert property (push_go |-> ##3 stk_done)
        else $error("stack operation did not finish on time");
    chk_pop_pc_valid: assert property (pop_go |-> ##4 (pc_out_valid && stk_done))
        else $error("popped program counter not presented");
    chk_never_paged: assert property (!mem_paged)
        else $error("stack access marked as paged");
    chk_fp_unpaged_cause: assert property (fp_unpaged |-> fp_access)
        else $error("frame pointer unpaged without an access");
    chk_move_full_ea: assert property (op_valid && op_class == SSA_INS_MOVE && op_mode == SSA_AM_DIRECT |=> op_ea == $past(op_full_addr))
        else $error("move address not taken whole");
    chk_mode_illegal: assert property (op_valid && op_class != SSA_INS_THREE && op_mode != SSA_AM_DIRECT |=> op_illegal)
        else $error("unsupported mode not flagged");
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the stack and addressing core.
// Assumes the core, its package and header, and the memory model are compiled first.
`include "ssa_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssa_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, op_full_addr = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, call_req = 1'b0, exc_req = 1'b0;
    logic ret_req = 1'b0, retfie_req = 1'b0, fp_access = 1'b0, op_dest_file = 1'b0;
    logic op_valid = 1'b0, stk_busy, stk_done, pc_out_valid, fp_unpaged, op_is_lit;
    logic op_illegal, op_dest_implied_work_alias, op_wb_direct, mem_wr, mem_rd, mem_paged;
    logic [22:0] pc_in = 23'h000000, pc_out, pc_cap;
    logic [1:0] op_class = 2'h0;
    logic [2:0] op_mode = 3'h0;
    logic [12:0] op_file_addr = 13'h0000;
    logic [9:0] op_literal = 10'h000;
    logic [15:0] op_ea, mem_addr, mem_wdata, mem_rdata, d;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial forever #2.5 clk_sys = ~clk_sys;
    ssa_core dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .call_req, .exc_req, .ret_req, .retfie_req, .pc_in, .stk_busy, .stk_done, .pc_out,
        .pc_out_valid, .fp_access, .fp_unpaged, .op_class, .op_mode, .op_file_addr,
        .op_full_addr, .op_literal, .op_dest_file, .op_valid, .op_ea, .op_is_lit,
        .op_illegal, .op_dest_implied_work_alias, .op_wb_direct, .mem_wr, .mem_rd, .mem_addr,
        .mem_wdata, .mem_paged, .mem_rdata);
    ssa_mem_model mem (.clk_sys, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata);
    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Kinds: 0 call, 1 exception, 2 return, 3 exception return.
    task automatic stk(input int k, input logic [22:0] pc);
        int n;
        @(posedge clk_sys);
        call_req <= (k == 0);
        exc_req <= (k == 1);
        ret_req <= (k == 2);
        retfie_req <= (k == 3);
        pc_in <= pc;
        @(posedge clk_sys);
        {call_req, exc_req, ret_req, retfie_req} <= 4'h0;
        for (n = 0; n < 10 && stk_done !== 1'b1; n++)
            #1 if (stk_done !== 1'b1) @(posedge clk_sys);
        chk16({15'h0000, stk_done}, 16'h0001);
        pc_cap = pc_out;
        @(posedge clk_sys);
    endtask
    task automatic op(input ssa_class_e c, input ssa_mode_e m, input logic [15:0] full);
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_class <= c;
        op_mode <= m;
        op_file_addr <= 13'h1abc;
        op_full_addr <= full;
        op_literal <= 10'h015;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`SSA_OFF_SP, d); chk16(d, 16'h1000);
        rd(`SSA_OFF_CORCTL, d); chk16(d, 16'h0020);
        rd(`SSA_OFF_STATUS, d); chk16(d, 16'h0000);
        rd(16'h0100, d); chk16(d, 16'h0000);
        wr(`SSA_OFF_SP, 16'h2001);
        rd(`SSA_OFF_SP, d); chk16(d, 16'h2000);
        stk(0, 23'h5a1234);
        chk16(mem.store[16'h1000], 16'h1234);
        chk16(mem.store[16'h1001], 16'h005a);
        rd(`SSA_OFF_SP, d); chk16(d, 16'h2004);
        wr(`SSA_OFF_STATUS, 16'h00a5);
        stk(1, 23'h3bcdef);
        chk16(mem.store[16'h1002], 16'hcdef);
        chk16(mem.store[16'h1003], 16'ha53b);
        rd(`SSA_OFF_SP, d); chk16(d, 16'h2008);
        wr(`SSA_OFF_STATUS, 16'h0000);
        stk(3, 23'h000000);
        chk16(pc_cap[15:0], 16'hcdef); chk16({9'h000, pc_cap[22:16]}, 16'h003b);
        rd(`SSA_OFF_STATUS, d); chk16(d & 16'h00ff, 16'h00a5);
        stk(2, 23'h000000);
        chk16(pc_cap[15:0], 16'h1234); chk16({9'h000, pc_cap[22:16]}, 16'h005a);
        rd(`SSA_OFF_SP, d); chk16(d, 16'h2000);
        wr(`SSA_OFF_CORCTL, 16'h0024);
        @(posedge clk_sys) fp_access <= 1'b1;
        #1 chk16({15'h0000, fp_unpaged}, 16'h0001);
        wr(`SSA_OFF_CORCTL, 16'h0020);
        #1 chk16({15'h0000, fp_unpaged}, 16'h0000);
        op(SSA_INS_FILE, SSA_AM_DIRECT, 16'hffff);
        chk16(op_ea, 16'h1abc);
        chk16({15'h0000, op_dest_implied_work_alias}, 16'h0001);
        op(SSA_INS_MOVE, SSA_AM_DIRECT, 16'hc012);
        chk16(op_ea, 16'hc012);
        op(SSA_INS_THREE, SSA_AM_LIT5, 16'h0000);
        chk16({15'h0000, op_is_lit}, 16'h0001);
        chk16(op_ea, 16'h0015);
        chk16({15'h0000, op_wb_direct}, 16'h0001);
        for (int m = 0; m < 6; m++)
        begin
            op(SSA_INS_THREE, ssa_mode_e'(m), 16'h0400);
            chk16({15'h0000, op_illegal}, 16'h0000);
        end
        op(SSA_INS_FILE, SSA_AM_POST, 16'h0000);
        chk16({15'h0000, op_illegal}, 16'h0001);
        final_report();
    end
endmodule
bind ssa_core ssa_core_chk chk (.clk_sys, .rst, .reg_addr, .reg_rd, .reg_rdata, .call_req,
    .exc_req, .ret_req, .retfie_req, .pc_in, .stk_busy, .stk_done, .pc_out_valid, .fp_access,
    .fp_unpaged, .op_class, .op_mode, .op_full_addr, .op_valid, .op_ea, .op_illegal,
    .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_paged);
